// ---- art_defs.svh ----
`ifndef ART_DEFS_SVH
`define ART_DEFS_SVH

// register offsets on the plain register port
`define ART_OFF_CTRL      4'h0
`define ART_OFF_RLD_LO    4'h1
`define ART_OFF_RLD_HI    4'h2
`define ART_OFF_CNT_LO    4'h3
`define ART_OFF_CNT_HI    4'h4
`define ART_OFF_CLKSEL    4'h5
`define ART_OFF_STATUS    4'h6

// control register field positions
`define ART_BIT_HI_OVF    7
`define ART_BIT_LO_OVF    6
`define ART_BIT_LO_IRQEN  5
`define ART_BIT_CAP_EN    4
`define ART_BIT_SPLIT     3
`define ART_BIT_RUN       2
`define ART_BIT_ALT_MSB   1
`define ART_BIT_ALT_LSB   0

// clock select register field positions
`define ART_BIT_LO_SYS    0
`define ART_BIT_HI_SYS    1
`define ART_BIT_TMR_IRQEN 2

// reset values
`define ART_RST_BYTE      8'h00
// every control bit is writable; the alternate select needs both low bits
`define ART_CTRL_MASK     8'hff
`define ART_CTRL_ALT_MASK 8'h03

// timing counts
`define ART_SYS_DIV       4'd12
`define ART_SYNC_CLOCKS   2'd3

`endif

// ---- art_pkg.sv ----
package art_pkg;

    // alternate clock choice when a byte does not use the system clock
    typedef enum logic [1:0]
    {
        ART_ALT_DIV12 = 2'b00,
        ART_ALT_EXT8  = 2'b01,
        ART_ALT_RSVD  = 2'b10,
        ART_ALT_LFO   = 2'b11
    } art_alt_type;

    // resync tracker after suspend, one-hot
    typedef enum logic [1:0]
    {
        ART_SYNC_IDLE = 2'b01,
        ART_SYNC_WAIT = 2'b10
    } art_sync_type;

endpackage

// ---- art_tick_gen.sv ----
`timescale 1ns/100ps
`include "art_defs.svh"

module art_tick_gen
(
    // clock and reset
    input  wire logic             mclk,
    input  wire logic             reset,
    // raw inputs from outside the domain
    input  wire logic             ext_clk_div8,
    input  wire logic             lfo_div8,
    input  wire logic             lfo_raw,
    input  wire logic             lfo_div_is_one,
    // selection
    input  wire logic             lo_sys,
    input  wire logic             hi_sys,
    input  wire logic [1:0]       alt_sel,
    // ticks out
    art_tick_if.gen               tk
);

    logic [2:0] ext_s;
    logic [2:0] lfo8_s;
    logic [2:0] lfo_s;
    logic [3:0] div12_cnt;
    logic       div12_tick;
    logic       ext_rise;
    logic       lfo8_rise;
    logic       alt_tick;

    // two flops before use, third flop only for edge detection
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            ext_s  <= 3'h0;
            lfo8_s <= 3'h0;
            lfo_s  <= 3'h7;
        end
        else
        begin
            ext_s  <= {ext_s[1:0], ext_clk_div8};   // RQ3
            lfo8_s <= {lfo8_s[1:0], lfo_div8};      // RQ3
            lfo_s  <= {lfo_s[1:0], lfo_raw};
        end
    end

    // system clock divided by twelve
    always_ff @(posedge mclk)
    begin
        if (reset)
            div12_cnt <= 4'h0;
        else if (div12_cnt == `ART_SYS_DIV - 4'd1)
            div12_cnt <= 4'h0;
        else
            div12_cnt <= div12_cnt + 4'd1;
    end

    assign div12_tick = (div12_cnt == `ART_SYS_DIV - 4'd1);
    assign ext_rise   = ext_s[1] & ~ext_s[2];
    // lfo path stays idle unless its own divider is one
    assign lfo8_rise  = lfo8_s[1] & ~lfo8_s[2] & lfo_div_is_one;  // RQ7

    // alternate source choice; reserved code never ticks
    always_comb
    begin
        case (art_pkg::art_alt_type'(alt_sel))
            art_pkg::ART_ALT_DIV12: alt_tick = div12_tick;
            art_pkg::ART_ALT_EXT8:  alt_tick = ext_rise;
            art_pkg::ART_ALT_LFO:   alt_tick = lfo8_rise;
            default:                alt_tick = 1'b0;
        endcase
    end

    assign tk.tick_lo  = lo_sys ? 1'b1 : alt_tick;  // RQ2 RQ13
    assign tk.tick_hi  = hi_sys ? 1'b1 : alt_tick;  // RQ13
    assign tk.lfo_fall = ~lfo_s[1] & lfo_s[2];
    assign tk.ext_edge = ext_rise | lfo8_rise;

endmodule

// ---- art_tick_if.sv ----
`timescale 1ns/100ps

// count enables from the tick generator to the counter
interface art_tick_if;
    logic tick_lo;
    logic tick_hi;
    logic lfo_fall;
    logic ext_edge;

    modport gen
    (
        output tick_lo,
        output tick_hi,
        output lfo_fall,
        output ext_edge
    );

    modport use_side
    (
        input tick_lo,
        input tick_hi,
        input lfo_fall,
        input ext_edge
    );
endinterface

// ---- art_timer.sv ----
// What this block does
// RQ1: sixteen-bit count in two bytes; split bit picks 16-bit or dual 8-bit
// RQ2: count clock from system_clock, system_clock/12, external/8 or lfo/8
// RQ3: divided external and lfo clocks are synchronised outside suspend
// RQ4: in suspend the divided clock drives the counter, still counting up
// RQ5: overflow in suspend wakes the device; preload sets the delay
// RQ6: sync pending flag up to three timer clocks after other wake
// RQ7: lfo clock counts only when the oscillator divider is one
// RQ8: 16-bit wrap reloads from reload bytes and sets high flag
// RQ9: 16-bit overflow requests interrupt when timer interrupt enabled
// RQ10: low byte wrap also interrupts when low interrupt enable set too
// RQ11: split mode: each byte reloads from its own reload byte
// RQ12: split mode: run bit gates only high byte, low always runs
// RQ13: per byte system_clock select, else alternate select picks the source
// RQ14: split mode: each byte wrap sets its own overflow flag
// RQ15: split interrupts on high wrap, either byte with low enable
// RQ16: overflow flags are only cleared by software
// RQ17: handler reads both flags to find the source
// RQ18: capture copies count to reload on lfo falling edge, sets high flag
// RQ19: software keeps split off while capture is active
// RQ20: capture clock must be much faster than the lfo
// RQ21: all counts, reloads and control clear at reset
`timescale 1ns/100ps
`include "art_defs.svh"

module art_timer
(
    // clock and reset
    input  wire logic             mclk,
    input  wire logic             reset,
    // register port
    input  wire logic [3:0]       reg_addr,
    input  wire logic [7:0]       reg_wdata,
    input  wire logic             reg_wr,
    input  wire logic             reg_rd,
    output logic      [7:0]       reg_rdata,
    // clock sources and power state
    input  wire logic             ext_clk_div8,
    input  wire logic             lfo_div8,
    input  wire logic             lfo_raw,
    input  wire logic             lfo_div_is_one,
    input  wire logic             suspend,
    input  wire logic             other_wake,
    // outputs
    output logic                  timer_irq,
    output logic                  wake_req,
    output logic                  timer_sync_pending
);

    logic [7:0] count_low_byte;
    logic [7:0] count_high_byte;
    logic [7:0] reload_low_byte;
    logic [7:0] reload_high_byte;
    logic [7:0] timer_control_reg;
    logic [2:0] clock_select_reg;
    logic [1:0] susp_s;
    logic [1:0] wake_s;
    logic       wake_seen;
    logic [1:0] sync_cnt;
    art_pkg::art_sync_type sync_state;

    logic       split_select;
    logic       high_byte_run;
    logic       lo_irq_en;
    logic       cap_en;
    logic       tmr_irq_en;
    logic       lo_wrap;
    logic       hi_wrap;
    logic       full_wrap;
    logic       set_hi;
    logic       set_lo;
    logic       wr_ctrl;
    logic       in_susp;
    logic [7:0] next_lo;
    logic [7:0] next_hi;
    logic [8:0] lo_inc;
    logic [8:0] hi_inc;

    art_tick_if tk ();

    assign split_select  = timer_control_reg[`ART_BIT_SPLIT];
    assign high_byte_run = timer_control_reg[`ART_BIT_RUN];
    assign lo_irq_en     = timer_control_reg[`ART_BIT_LO_IRQEN];
    assign cap_en        = timer_control_reg[`ART_BIT_CAP_EN];
    assign tmr_irq_en    = clock_select_reg[`ART_BIT_TMR_IRQEN];
    assign in_susp       = susp_s[1];

    // tick sources and synchronisers live in the leaf
    art_tick_gen u_tick
    (
        .mclk           (mclk),
        .reset          (reset),
        .ext_clk_div8   (ext_clk_div8),
        .lfo_div8       (lfo_div8),
        .lfo_raw        (lfo_raw),
        .lfo_div_is_one (lfo_div_is_one),
        .lo_sys         (clock_select_reg[`ART_BIT_LO_SYS]),
        .hi_sys         (clock_select_reg[`ART_BIT_HI_SYS]),
        .alt_sel        (timer_control_reg[`ART_BIT_ALT_MSB:`ART_BIT_ALT_LSB]),
        .tk             (tk)
    );

    // byte increment with wrap detection, shared by both bytes
    function automatic logic [8:0] inc_byte(input logic [7:0] v);
        inc_byte = {1'b0, v} + 9'h001;
    endfunction

    // carry into bit 8 marks a byte wrap from 0xff to 0x00
    assign lo_inc = inc_byte(count_low_byte);
    assign hi_inc = inc_byte(count_high_byte);

    // power state inputs come from another domain
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            susp_s <= 2'b00;
            wake_s <= 2'b00;
        end
        else
        begin
            susp_s <= {susp_s[0], suspend};
            wake_s <= {wake_s[0], other_wake};
        end
    end

    // overflow detection for each mode
    always_comb
    begin
        lo_wrap   = 1'b0;
        hi_wrap   = 1'b0;
        full_wrap = 1'b0;
        if (split_select)
        begin
            lo_wrap = tk.tick_lo & lo_inc[8];  // RQ12
            hi_wrap = tk.tick_hi & high_byte_run
                    & hi_inc[8];
        end
        else if (high_byte_run)
        begin
            lo_wrap   = tk.tick_lo & lo_inc[8];
            full_wrap = lo_wrap & hi_inc[8];
        end
    end

    // next count values; the tick is the synchronised divided clock,
    // which in suspend is the only thing still moving the counter
    always_comb
    begin
        next_lo = count_low_byte;
        next_hi = count_high_byte;
        if (split_select)
        begin
            // RQ11
            if (tk.tick_lo)
                next_lo = lo_wrap ? reload_low_byte
                                  : lo_inc[7:0];
            if (tk.tick_hi && high_byte_run)
                next_hi = hi_wrap ? reload_high_byte
                                  : hi_inc[7:0];
        end
        else if (high_byte_run && tk.tick_lo)
        begin
            // RQ1 RQ4
            if (full_wrap)
            begin
                next_lo = reload_low_byte;   // RQ8
                next_hi = reload_high_byte;  // RQ8
            end
            else
            begin
                next_lo = lo_inc[7:0];
                next_hi = lo_wrap ? hi_inc[7:0]
                                  : count_high_byte;
            end
        end
    end

    // counter bytes; software write takes priority over counting
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            count_low_byte  <= `ART_RST_BYTE;  // RQ21
            count_high_byte <= `ART_RST_BYTE;
        end
        else
        begin
            count_low_byte  <= next_lo;
            count_high_byte <= next_hi;
            if (reg_wr && reg_addr == `ART_OFF_CNT_LO)
                count_low_byte <= reg_wdata;  // RQ5
            if (reg_wr && reg_addr == `ART_OFF_CNT_HI)
                count_high_byte <= reg_wdata;
        end
    end

    // reload bytes; capture overwrites them with the live count
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            reload_low_byte  <= `ART_RST_BYTE;
            reload_high_byte <= `ART_RST_BYTE;
        end
        else if (cap_en && tk.lfo_fall)
        begin
            reload_low_byte  <= count_low_byte;   // RQ18
            reload_high_byte <= count_high_byte;  // RQ18
        end
        else if (reg_wr)
        begin
            if (reg_addr == `ART_OFF_RLD_LO)
                reload_low_byte <= reg_wdata;
            if (reg_addr == `ART_OFF_RLD_HI)
                reload_high_byte <= reg_wdata;
        end
    end

    assign set_hi  = hi_wrap | full_wrap | (cap_en & tk.lfo_fall);
    assign set_lo  = lo_wrap;
    assign wr_ctrl = reg_wr && reg_addr == `ART_OFF_CTRL;

    // control register; hardware only sets flags, and a set beats a clear
    always_ff @(posedge mclk)
    begin
        if (reset)
            timer_control_reg <= `ART_RST_BYTE;
        else
        begin
            if (wr_ctrl)
                timer_control_reg <= reg_wdata & `ART_CTRL_MASK;
            if (set_hi)
                timer_control_reg[`ART_BIT_HI_OVF] <= 1'b1;  // RQ8 RQ14 RQ16
            if (set_lo)
                timer_control_reg[`ART_BIT_LO_OVF] <= 1'b1;  // RQ14 RQ16
        end
    end

    // per byte system_clock selects and timer interrupt enable
    always_ff @(posedge mclk)
    begin
        if (reset)
            clock_select_reg <= 3'h0;
        else if (reg_wr && reg_addr == `ART_OFF_CLKSEL)
            clock_select_reg <= reg_wdata[2:0];
    end

    // interrupt is a level from the flags so software sees both sources
    always_ff @(posedge mclk)
    begin
        if (reset)
            timer_irq <= 1'b0;
        else
            timer_irq <= tmr_irq_en
                       & (timer_control_reg[`ART_BIT_HI_OVF]  // RQ9 RQ15
                       | (lo_irq_en
                          & timer_control_reg[`ART_BIT_LO_OVF]));  // RQ10
    end

    // wake request while suspended on a high flag set, or on a low byte wrap in split mode only
    always_ff @(posedge mclk)
    begin
        if (reset)
            wake_req <= 1'b0;
        else if (!in_susp)
            wake_req <= 1'b0;
        else if (set_hi || (split_select && set_lo))
            wake_req <= 1'b1;  // RQ5
    end

    // a foreign wake leaves the timer unsafe until three timer ticks pass
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            sync_state <= art_pkg::ART_SYNC_IDLE;
            sync_cnt   <= 2'd0;
            wake_seen  <= 1'b0;
        end
        else
        begin
            wake_seen <= wake_s[1];
            case (sync_state)
                art_pkg::ART_SYNC_IDLE:
                    if (wake_s[1] && !wake_seen && !wake_req)
                    begin
                        sync_state <= art_pkg::ART_SYNC_WAIT;  // RQ6
                        sync_cnt   <= 2'd0;
                    end
                art_pkg::ART_SYNC_WAIT:
                    if (tk.ext_edge || tk.tick_lo)
                    begin
                        if (sync_cnt == `ART_SYNC_CLOCKS - 2'd1)
                            sync_state <= art_pkg::ART_SYNC_IDLE;
                        else
                            sync_cnt <= sync_cnt + 2'd1;
                    end
                default:
                    sync_state <= art_pkg::ART_SYNC_IDLE;
            endcase
        end
    end

    assign timer_sync_pending = (sync_state == art_pkg::ART_SYNC_WAIT);

    // read data appears in the cycle after the strobe; unmapped reads zero
    always_ff @(posedge mclk)
    begin
        if (reset)
            reg_rdata <= 8'h00;
        else if (reg_rd)
        begin
            case (reg_addr)
                `ART_OFF_CTRL:   reg_rdata <= timer_control_reg;
                `ART_OFF_RLD_LO: reg_rdata <= reload_low_byte;
                `ART_OFF_RLD_HI: reg_rdata <= reload_high_byte;
                `ART_OFF_CNT_LO: reg_rdata <= count_low_byte;
                `ART_OFF_CNT_HI: reg_rdata <= count_high_byte;
                `ART_OFF_CLKSEL: reg_rdata <= {5'h00, clock_select_reg};
                `ART_OFF_STATUS: reg_rdata <= {6'h00, wake_req,
                                               timer_sync_pending};
                default:         reg_rdata <= 8'h00;
            endcase
        end
        else
            reg_rdata <= 8'h00;
    end

endmodule

// ---- art_timer_properties.sv ----
`timescale 1ns/100ps

module art_timer_chk
(
    // clock and reset
    input wire logic       mclk,
    input wire logic       reset,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    // power state and outputs
    input wire logic       suspend,
    input wire logic       timer_irq,
    input wire logic       wake_req,
    input wire logic       timer_sync_pending
);
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);

    // everything quiet on the first edge out of reset
    AST_RST_CLEAR: assert property ($fell(reset) |-> !timer_irq && !wake_req
        && !timer_sync_pending && reg_rdata == 8'h00)
        else $error("outputs not clear after reset");
    AST_RDATA_IDLE: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data outside read slot");
    AST_UNMAPPED: assert property (reg_rd && reg_addr > 4'h6 |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    AST_STATUS: assert property (reg_rd && reg_addr == 4'h6 |=> reg_rdata ==
        {6'h00, $past(wake_req), $past(timer_sync_pending)})
        else $error("status read wrong");
    AST_RELOAD_BACK: assert property (reg_wr && reg_addr == 4'h2 ##2
        reg_rd && reg_addr == 4'h2 |=> reg_rdata == $past(reg_wdata, 3))
        else $error("reload readback wrong");
    // only a software write may take the request away
    AST_IRQ_HOLD: assert property (timer_irq && !reg_wr && !$past(reg_wr)
        |=> timer_irq)
        else $error("interrupt dropped without write");
    // suspend passes two flops, so the wake rises three edges after it
    AST_WAKE_SUSP: assert property ($rose(wake_req) |-> $past(suspend, 3))
        else $error("wake outside suspend");
    AST_WAKE_DROP: assert property (!suspend [*5] |-> !wake_req)
        else $error("wake held after suspend");
    AST_SYNC_END: assert property ($rose(timer_sync_pending)
        |-> ##[1:100] !timer_sync_pending)
        else $error("sync pending stuck");

    C_WAKE: cover property ($rose(wake_req));
    C_IRQ: cover property ($rose(timer_irq));
    C_SYNC: cover property ($rose(timer_sync_pending));
endmodule

bind art_timer art_timer_chk u_art_timer_chk
(
    .mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .suspend(suspend), .timer_irq(timer_irq), .wake_req(wake_req),
    .timer_sync_pending(timer_sync_pending)
);

// ---- tb.sv ----
`timescale 1ns/100ps
`define CHK(got, exp) \
begin total_checks++; if ((got) !== (exp)) begin num_errors++; \
$display("mismatch at %0t: got %h exp %h", $time, got, exp); end end

module tb;
    logic       mclk, reset, reg_wr, reg_rd, suspend, other_wake;
    logic       ext_clk_div8, lfo_div8, lfo_raw, lfo_div_is_one;
    logic       timer_irq, wake_req, timer_sync_pending;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, rv;
    int         num_errors, total_checks;

    art_timer u_art_timer
    (
        .mclk(mclk), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .ext_clk_div8(ext_clk_div8),
        .lfo_div8(lfo_div8), .lfo_raw(lfo_raw),
        .lfo_div_is_one(lfo_div_is_one), .suspend(suspend),
        .other_wake(other_wake), .timer_irq(timer_irq),
        .wake_req(wake_req), .timer_sync_pending(timer_sync_pending)
    );

    // 200 MHz system clock
    initial
    begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    task cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask

    // an idle edge first, so a strobe is never set and cleared in one step
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask

    task rd(input logic [3:0] a);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 rv = reg_rdata;
    endtask

    // slow edges on the divided ext or lfo clock, well apart for the syncer
    task ticks(input bit low_freq_oscillator, input int n);
        repeat (n)
        begin
            cyc(4);
            if (low_freq_oscillator) lfo_div8 <= 1'b1; else ext_clk_div8 <= 1'b1;
            cyc(4);
            lfo_div8 <= 1'b0;
            ext_clk_div8 <= 1'b0;
        end
    endtask

    task t_reset;
        for (int a = 0; a < 16; a++)
        begin
            rd(4'(a));
            `CHK(rv, 8'h00)
        end
    endtask

    task t_16bit;
        wr(4'h5, 8'h05); wr(4'h1, 8'h34); wr(4'h2, 8'h12);
        wr(4'h3, 8'hfe); wr(4'h4, 8'hff); wr(4'h0, 8'h04);
        cyc(6); #1;
        `CHK(timer_irq, 1'b1)
        rd(4'h0); `CHK(rv[7], 1'b1)
        wr(4'h0, 8'h00);
        rd(4'h4); `CHK(rv, 8'h12)
        `CHK(timer_irq, 1'b0)
        wr(4'h4, 8'h00); wr(4'h3, 8'hfc); wr(4'h0, 8'h04);
        cyc(10); #1;
        `CHK(timer_irq, 1'b0)
        rd(4'h0); `CHK(rv[7:6], 2'b01)
        wr(4'h0, 8'h64); cyc(2); #1;
        `CHK(timer_irq, 1'b1)
        wr(4'h0, 8'h00);
    endtask

    // reload f0 keeps the low byte's top nibble fixed whatever the phase; e0 keeps the high one at e for 16 ticks only
    task t_split;
        wr(4'h5, 8'h03); wr(4'h1, 8'hf0); wr(4'h2, 8'he0);
        rd(4'h2); `CHK(rv, 8'he0)
        wr(4'h3, 8'hfe); wr(4'h4, 8'hfe); wr(4'h0, 8'h08);
        cyc(8);
        rd(4'h4); `CHK(rv, 8'hfe)
        rd(4'h0); `CHK(rv[7:6], 2'b01)
        rd(4'h3); `CHK(rv[7:4], 4'hf)
        wr(4'h0, 8'h0c); cyc(8);
        rd(4'h4); `CHK(rv[7:4], 4'he)
        rd(4'h0); `CHK(rv[7], 1'b1)
        `CHK(timer_irq, 1'b0)
        wr(4'h5, 8'h07); cyc(2); #1;
        `CHK(timer_irq, 1'b1)
        wr(4'h0, 8'h28); cyc(20); #1;
        `CHK(timer_irq, 1'b1)
        rd(4'h0); `CHK(rv[7:6], 2'b01)
        wr(4'h0, 8'h48); cyc(2); #1;
        `CHK(timer_irq, 1'b0)
        wr(4'h0, 8'h00);
    endtask

    task t_src;
        wr(4'h5, 8'h00); wr(4'h4, 8'h00); wr(4'h3, 8'h00);
        wr(4'h0, 8'h05); ticks(0, 5); cyc(4);
        rd(4'h3); `CHK(rv, 8'h05)
        lfo_div_is_one <= 1'b1;
        wr(4'h3, 8'h00); wr(4'h0, 8'h07); ticks(1, 4); cyc(4);
        rd(4'h3); `CHK(rv, 8'h04)
        lfo_div_is_one <= 1'b0;
        ticks(1, 3); cyc(4);
        rd(4'h3); `CHK(rv, 8'h04)
        wr(4'h0, 8'h00); wr(4'h3, 8'h00); wr(4'h0, 8'h04); cyc(118);
        rd(4'h3); `CHK(rv inside {[8'h09:8'h0b]}, 1'b1)
        wr(4'h0, 8'h00);
    endtask

    task t_capture;
        wr(4'h5, 8'h01); wr(4'h3, 8'h00); wr(4'h4, 8'h00);
        wr(4'h1, 8'h00); wr(4'h2, 8'h00); wr(4'h0, 8'h14);
        cyc(20); lfo_raw <= 1'b0; cyc(6); lfo_raw <= 1'b1;
        rd(4'h0); `CHK(rv[7], 1'b1)
        rd(4'h2); `CHK(rv, 8'h00)
        rd(4'h1); `CHK(rv inside {[8'h10:8'h30]}, 1'b1)
        wr(4'h0, 8'h00);
    endtask

    task t_suspend;
        wr(4'h5, 8'h00); wr(4'h4, 8'hff); wr(4'h3, 8'hfd); wr(4'h0, 8'h05);
        suspend <= 1'b1;
        ticks(0, 2); cyc(4); #1;
        `CHK(wake_req, 1'b0)
        ticks(0, 1); cyc(6); #1;
        `CHK(wake_req, 1'b1)
        rd(4'h6); `CHK(rv[1], 1'b1)
        suspend <= 1'b0;
        cyc(8); #1;
        `CHK(wake_req, 1'b0)
        wr(4'h0, 8'h00);
    endtask

    task t_sync;
        wr(4'h5, 8'h01);
        other_wake <= 1'b1;
        // look just after each edge, once the flag has settled
        for (int i = 0; i < 10 && timer_sync_pending !== 1'b1; i++)
        begin
            cyc(1);
            #1;
        end
        `CHK(timer_sync_pending, 1'b1)
        for (int i = 0; i < 20 && timer_sync_pending !== 1'b0; i++)
        begin
            cyc(1);
            #1;
        end
        `CHK(timer_sync_pending, 1'b0)
        other_wake <= 1'b0;
    endtask

    task report_and_stop;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // a hang costs far more than the few hundred cycles the run needs
    initial
    begin
        #40000;
        num_errors++;
        report_and_stop;
    end

    initial
    begin
        reset = 1'b1; reg_addr = 4'h0; reg_wdata = 8'h00; reg_wr = 1'b0;
        reg_rd = 1'b0; ext_clk_div8 = 1'b0; lfo_div8 = 1'b0; lfo_raw = 1'b1;
        lfo_div_is_one = 1'b0; suspend = 1'b0; other_wake = 1'b0;
        num_errors = 0; total_checks = 0;
        cyc(4);
        reset <= 1'b0;
        t_reset; t_16bit; t_split; t_src; t_capture; t_suspend; t_sync;
        report_and_stop;
    end
endmodule
